// ==== logic/dsr_pkg.sv ====
// Constants shared by the shift register and its output buffer
// Notes on behaviour
// - Four stages exist that can both shift right and load in parallel on a clock.
// - Stages change only on the falling edge of the effective clock, never on its rise.
// - With load select low each stage feeds the next, so a clock moves data one place right.
// - With load select high a clock copies the four parallel inputs into the four stages.
// - In shift mode only the first clock input advances the register.
// - In shift mode the first stage takes the serial data input.
// - In shift mode the second clock and the parallel inputs are ignored.
// - In load mode the stage-to-stage path is cut and the stages take the parallel inputs.
// - The effective clock is clock one gated by shift mode ORed with clock two gated by load mode.
// - There is no master reset or clear; stages are set only by shift or load.
// - Devices cascade by feeding the last stage output into the next serial input.
// - Every stage output is visible at all times.
package dsr_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned DSR_WIDTH     = 4;
    localparam int unsigned DSR_BUF_DEPTH = 2;
    localparam int unsigned DSR_PIN_COUNT = 8;

    // ------------------------------------------------------------
    // Pin positions inside the synchroniser word
    // ------------------------------------------------------------
    localparam int unsigned DSR_PIN_SHIFT_CLK = 0;
    localparam int unsigned DSR_PIN_LOAD_CLK  = 1;
    localparam int unsigned DSR_PIN_LOAD_SEL  = 2;
    localparam int unsigned DSR_PIN_SERIAL    = 3;
    localparam int unsigned DSR_PIN_DATA_LSB  = 4;

    // ------------------------------------------------------------
    // Values after reset, and the buffer's full count
    // ------------------------------------------------------------
    localparam logic [DSR_PIN_COUNT-1:0] DSR_PINS_RST  = 8'h00;
    localparam logic [DSR_WIDTH-1:0]     DSR_WORD_RST  = 4'h0;
    localparam logic [1:0]               DSR_COUNT_RST = 2'h0;
    localparam logic [1:0]               DSR_COUNT_FULL = 2'h2;

endpackage : dsr_pkg

// ==== logic/dsr_stream_if.sv ====
// Valid/ready word stream between the register core and its buffer
`timescale 1ns/1ps
interface dsr_stream_if;
    import dsr_pkg::*;

    logic                 valid;
    logic                 ready;
    logic [DSR_WIDTH-1:0] data;

    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);

endinterface : dsr_stream_if

// ==== logic/dsr_pair_buf.sv ====
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module dsr_pair_buf
    import dsr_pkg::*;
(
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    dsr_stream_if.snk                 in_s,
    output logic                      out_valid_o,
    output logic [DSR_WIDTH-1:0]      out_data_o,
    input  wire logic                 out_ready_i
);

    typedef struct packed {
        logic [DSR_BUF_DEPTH-1:0][DSR_WIDTH-1:0] ent;
        logic [1:0]                              cnt;
        logic                                    vld;
        logic                                    rdy;
    } dsr_buf_state_t;

    dsr_buf_state_t st;
    dsr_buf_state_t next_st;
    logic           push;
    logic           pop;

    assign push = in_s.valid & st.rdy;
    assign pop  = st.vld & out_ready_i;

    // Entry zero is always the head, so the output is a plain flop
    always_comb
    begin
        next_st = st;
        if (pop)
        begin
            next_st.ent[0] = st.ent[1];
            next_st.cnt    = next_st.cnt - 2'h1;
        end
        if (push)
        begin
            next_st.ent[next_st.cnt[0]] = in_s.data;
            next_st.cnt                 = next_st.cnt + 2'h1;
        end
        next_st.vld = (next_st.cnt != DSR_COUNT_RST);
        next_st.rdy = (next_st.cnt != DSR_COUNT_FULL);
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st.ent <= {DSR_BUF_DEPTH{DSR_WORD_RST}};
            st.cnt <= DSR_COUNT_RST;
            st.vld <= 1'b0;
            st.rdy <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign in_s.ready  = st.rdy;
    assign out_valid_o = st.vld;
    assign out_data_o  = st.ent[0];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_buf_fills_up: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (push && !pop && st.cnt == 2'h1) |=> !in_s.ready && out_valid_o)
        else $error("Buffer did not report full after second word");

    a_buf_keeps_order: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (pop && st.cnt == 2'h2) |=> out_valid_o && out_data_o == $past(st.ent[1]))
        else $error("Buffer lost the second word on pop");

endmodule // dsr_pair_buf

// ==== logic/dsr_shift_reg.sv ====
// Four-stage dual-clock shift register with parallel load and word stream
`timescale 1ns/1ps
module dsr_shift_reg
    import dsr_pkg::*;
(
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 shift_clk_i,
    input  wire logic                 load_clk_i,
    input  wire logic                 load_select_i,
    input  wire logic                 serial_i,
    input  wire logic [DSR_WIDTH-1:0] load_data_i,
    output logic      [DSR_WIDTH-1:0] stage_out_o,
    output logic                      accept_ready_o,
    output logic                      word_valid_o,
    output logic      [DSR_WIDTH-1:0] word_data_o,
    input  wire logic                 word_ready_i
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DSR_PIN_COUNT-1:0] pin_meta;
        logic [DSR_PIN_COUNT-1:0] pin_sync;
        logic                     eff_prev;
        logic                     filled;
        logic                     push_vld;
        logic [DSR_WIDTH-1:0]     push_data;
    } dsr_core_state_t;

    dsr_core_state_t      st;
    dsr_core_state_t      next_st;
    logic [DSR_WIDTH-1:0] stages;
    logic [DSR_WIDTH-1:0] next_stages;

    logic                 s_shift_clk;
    logic                 s_load_clk;
    logic                 s_load_sel;
    logic                 s_serial;
    logic [DSR_WIDTH-1:0] s_load_data;
    logic                 eff_clk;
    logic                 eff_fall;

    dsr_stream_if word_s ();

    // ------------------------------------------------------------
    // Synchronised pin view
    // ------------------------------------------------------------
    assign s_shift_clk = st.pin_sync[DSR_PIN_SHIFT_CLK];
    assign s_load_clk  = st.pin_sync[DSR_PIN_LOAD_CLK];
    assign s_load_sel  = st.pin_sync[DSR_PIN_LOAD_SEL];
    assign s_serial    = st.pin_sync[DSR_PIN_SERIAL];
    assign s_load_data = st.pin_sync[DSR_PIN_DATA_LSB +: DSR_WIDTH];

    // ------------------------------------------------------------
    // Effective clock and its falling edge
    // ------------------------------------------------------------
    // Mode is assumed to change only while both clocks are low
    assign eff_clk  = (s_shift_clk & ~s_load_sel) | (s_load_clk & s_load_sel);
    assign eff_fall = st.eff_prev & ~eff_clk;

    // ------------------------------------------------------------
    // Stage update
    // ------------------------------------------------------------
    always_comb
    begin
        next_stages = stages;
        if (eff_fall)
        begin
            if (s_load_sel)
            begin
                next_stages = s_load_data;
            end
            else
            begin
                next_stages = {stages[DSR_WIDTH-2:0], s_serial};
            end
        end
    end

    // Stages carry no reset; only shift or load sets them
    always_ff @(posedge ref_clk_i)
    begin
        stages <= next_stages;
    end

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st          = st;
        next_st.pin_meta = {load_data_i, serial_i, load_select_i, load_clk_i, shift_clk_i};
        next_st.pin_sync = st.pin_meta;
        next_st.eff_prev = eff_clk;
        // Flag sets on any update; stages are all known once a load or four shifts have landed
        next_st.filled   = st.filled | eff_fall;
        if (word_s.ready)
        begin
            next_st.push_vld = 1'b0;
        end
        // Each new stage word is offered downstream; a stalled word is replaced
        if (eff_fall)
        begin
            next_st.push_vld  = 1'b1;
            next_st.push_data = next_stages;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st.pin_meta  <= DSR_PINS_RST;
            st.pin_sync  <= DSR_PINS_RST;
            st.eff_prev  <= 1'b0;
            st.filled    <= 1'b0;
            st.push_vld  <= 1'b0;
            st.push_data <= DSR_WORD_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------
    assign word_s.valid = st.push_vld;
    assign word_s.data  = st.push_data;

    dsr_pair_buf u_buf (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .in_s        (word_s),
        .out_valid_o (word_valid_o),
        .out_data_o  (word_data_o),
        .out_ready_i (word_ready_i)
    );

    // Last stage doubles as the cascade output
    assign stage_out_o    = stages;
    assign accept_ready_o = word_s.ready;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_shift_fall;
        eff_fall && !s_load_sel;
    endsequence

    sequence s_load_fall;
        eff_fall && s_load_sel;
    endsequence

    a_shift_moves_right: assert property (
        st.filled ##0 s_shift_fall |=>
            stage_out_o == {$past(stages[DSR_WIDTH-2:0]), $past(s_serial)})
        else $error("Shift did not move stages right");

    a_serial_enters_first: assert property (
        s_shift_fall |=> stage_out_o[0] == $past(s_serial))
        else $error("First stage did not take serial input");

    a_load_copies_data: assert property (
        s_load_fall |=> stage_out_o == $past(s_load_data))
        else $error("Load did not copy parallel inputs");

    a_rise_no_change: assert property (
        (st.filled && eff_clk && !st.eff_prev) |=> stage_out_o == $past(stages))
        else $error("Stages changed on rising edge");

    a_hold_without_fall: assert property (
        (st.filled && !eff_fall ##1 !eff_fall) |=> stage_out_o == $past(stages, 2))
        else $error("Stages changed without a falling edge");

    a_shift_ignores_clk2: assert property (
        (!s_load_sel && !s_shift_clk) |-> !eff_clk)
        else $error("Second clock reached register in shift mode");

    a_load_ignores_clk1: assert property (
        (s_load_sel && !s_load_clk) |-> !eff_clk)
        else $error("First clock reached register in load mode");

    a_word_follows_fall: assert property (
        eff_fall |=> st.push_vld && st.push_data == stages)
        else $error("Stage word not offered after update");

    a_word_waits_ready: assert property (
        (st.push_vld && !word_s.ready && !eff_fall) |=> st.push_vld && $stable(st.push_data))
        else $error("Stalled word was dropped");

endmodule // dsr_shift_reg

// ==== verif/dsr_sink_model.sv ====
// Consumer model for the shift register's word stream
`timescale 1ns/1ps
module dsr_sink_model
    import dsr_pkg::*;
(
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 valid_i,
    input  wire logic [DSR_WIDTH-1:0] data_i,
    input  wire logic                 stall_i,
    output logic                      ready_o
);
    // ------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------
    logic [DSR_WIDTH-1:0] got[$];

    // Stall lets the bench hold words back in the buffer
    assign ready_o = !stall_i;

    always @(posedge ref_clk_i)
    begin
        if (!rst_i && valid_i && ready_o)
            got.push_back(data_i);
    end
endmodule // dsr_sink_model

// ==== verif/dsr_shift_reg_tb_top.sv ====
// Self-checking bench for the four-stage dual-clock shift register
`timescale 1ns/1ps
module dsr_shift_reg_tb_top;
    import dsr_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                 ref_clk_i;
    logic                 rst_i;
    logic                 clk1;
    logic                 clk2;
    logic                 sel;
    logic                 ser;
    logic [DSR_WIDTH-1:0] dat;
    logic [DSR_WIDTH-1:0] stage;
    logic                 acc_rdy;
    logic                 w_valid;
    logic [DSR_WIDTH-1:0] w_data;
    logic                 w_ready;
    logic                 stall;
    logic [DSR_WIDTH-1:0] exp_q[$];
    int                   err_count;
    int                   n_compared;
    int                   cycles;

    dsr_shift_reg dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .shift_clk_i(clk1),
        .load_clk_i(clk2), .load_select_i(sel), .serial_i(ser), .load_data_i(dat),
        .stage_out_o(stage), .accept_ready_o(acc_rdy), .word_valid_o(w_valid),
        .word_data_o(w_data), .word_ready_i(w_ready));

    dsr_sink_model sink_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .valid_i(w_valid),
        .data_i(w_data), .stall_i(stall), .ready_o(w_ready));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            err_count = err_count + 1;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Mode and data settle first, clocks rise, then fall together
    task automatic step(input logic c1, input logic c2, input logic s, input logic sr,
                        input logic [3:0] d, input logic [3:0] exp, input logic ev);
        logic [3:0] old;
        old = stage;
        @(posedge ref_clk_i);
        sel <= s;
        ser <= sr;
        dat <= d;
        repeat (4) @(posedge ref_clk_i);
        clk1 <= c1;
        clk2 <= c2;
        repeat (6) @(posedge ref_clk_i);
        check("stage_after_rise", stage, old);
        clk1 <= 1'b0;
        clk2 <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        check("stage_after_fall", stage, exp);
        if (ev)
            exp_q.push_back(exp);
    endtask

    task automatic check_words();
        repeat (4) @(posedge ref_clk_i);
        check("word_count", 4'(sink_u.got.size()), 4'(exp_q.size()));
        while (exp_q.size() > 0 && sink_u.got.size() > 0)
            check("word", sink_u.got.pop_front(), exp_q.pop_front());
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_load_shift();
        step(1'b0, 1'b1, 1'b1, 1'b0, 4'hA, 4'hA, 1'b1);
        step(1'b1, 1'b0, 1'b0, 1'b1, 4'h3, 4'h5, 1'b1);
        step(1'b1, 1'b0, 1'b0, 1'b0, 4'hF, 4'hA, 1'b1);
        check_words();
    endtask

    task automatic t_ignored();
        step(1'b0, 1'b1, 1'b0, 1'b1, 4'hF, 4'hA, 1'b0);
        step(1'b1, 1'b0, 1'b1, 1'b0, 4'h6, 4'hA, 1'b0);
        check_words();
    endtask

    task automatic t_common_left();
        step(1'b1, 1'b1, 1'b1, 1'b0, 4'h6, 4'h6, 1'b1);
        step(1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 4'hD, 1'b1);
        step(1'b0, 1'b1, 1'b1, 1'b0, {1'b1, stage[3:1]}, 4'hE, 1'b1);
        check_words();
    endtask

    task automatic t_reset_keeps();
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        check("stage_after_reset", stage, 4'hE);
        check("valid_after_reset", {3'h0, w_valid}, 4'h0);
        check("ready_after_reset", {3'h0, acc_rdy}, 4'h1);
    endtask

    task automatic t_buffer_full();
        stall <= 1'b1;
        step(1'b0, 1'b1, 1'b1, 1'b0, 4'h3, 4'h3, 1'b1);
        step(1'b0, 1'b1, 1'b1, 1'b0, 4'hC, 4'hC, 1'b1);
        check("accept_ready_full", {3'h0, acc_rdy}, 4'h0);
        check("valid_held", {3'h0, w_valid}, 4'h1);
        check("head_word", w_data, 4'h3);
        stall <= 1'b0;
        check_words();
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        rst_i = 1'b1;
        clk1 = 1'b0;
        clk2 = 1'b0;
        sel = 1'b0;
        ser = 1'b0;
        dat = 4'h0;
        stall = 1'b0;
        err_count = 0;
        n_compared = 0;
        cycles = 0;
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_load_shift();
        t_ignored();
        t_common_left();
        t_reset_keeps();
        t_buffer_full();
        summarize();
    end
endmodule // dsr_shift_reg_tb_top
